// >>> rtl/tws_pkg.sv
package tws_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_COMMON_CONFIG = 4'h0;
  localparam logic [3:0] IDX_DUAL_MODE_CONFIG = 4'h1;
  localparam logic [3:0] IDX_DEBUG_HALT_CONTROL = 4'h2;
  localparam logic [3:0] IDX_HOST_CONTROL_FIRST = 4'h3;
  localparam logic [3:0] IDX_HOST_CONTROL_SECOND = 4'h4;
  localparam logic [3:0] IDX_HOST_STATUS = 4'h5;
  localparam logic [3:0] IDX_HOST_BAUD_DIVIDER = 4'h6;
  localparam logic [3:0] IDX_HOST_TARGET_ADDRESS = 4'h7;
  localparam logic [3:0] IDX_HOST_DATA = 4'h8;
  localparam logic [3:0] IDX_CLIENT_CONTROL_FIRST = 4'h9;
  localparam logic [3:0] IDX_CLIENT_CONTROL_SECOND = 4'ha;
  localparam logic [3:0] IDX_CLIENT_STATUS = 4'hb;
  localparam logic [3:0] IDX_CLIENT_OWN_ADDRESS = 4'hc;
  localparam logic [3:0] IDX_CLIENT_DATA = 4'hd;
  localparam logic [3:0] IDX_CLIENT_ADDRESS_MASK = 4'he;
  // Field positions
  localparam int BIT_INPUT_THRESHOLD = 6;
  localparam int BIT_DATA_SETUP = 4;
  localparam int BIT_HOLD_HI = 3;
  localparam int BIT_HOLD_LO = 2;
  localparam int BIT_FAST_PLUS = 1;
  localparam int BIT_DUAL_ENABLE = 0;
  localparam int BIT_RUN_HALTED = 0;
  localparam int BIT_HOST_READ_IEN = 7;
  localparam int BIT_HOST_WRITE_IEN = 6;
  localparam int BIT_HOST_ENABLE = 0;
  localparam int BIT_CLIENT_ENABLE = 0;
  localparam int BIT_READ_DONE = 7;
  localparam int BIT_WRITE_DONE = 6;
  localparam int BIT_DATA_FLAG = 7;
  localparam int BIT_ADDR_STOP_FLAG = 6;
  // Writable bit masks and reset value
  localparam logic [7:0] MASK_COMMON = 8'h5e;
  localparam logic [7:0] MASK_DUAL = 8'h4f;
  localparam logic [7:0] MASK_DEBUG = 8'h01;
  localparam logic [7:0] MASK_HOST_CTRL2 = 8'h04;
  localparam logic [7:0] MASK_HOST_STATUS_RW = 8'h3c;
  localparam logic [7:0] MASK_CLIENT_CTRL2 = 8'h04;
  localparam logic [7:0] MASK_CLIENT_STATUS_RW = 8'h3f;
  localparam logic [7:0] RESET_REG = 8'h00;
  // Bus state codes in the host status low bits
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_BUSY = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int HOLD_SHORT_NS = 50;
  localparam int HOLD_NOMINAL_NS = 300;
  localparam int HOLD_LONG_NS = 500;
  localparam logic [6:0] HOLD_SHORT_CYC =
    7'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] HOLD_NOMINAL_CYC =
    7'((HOLD_NOMINAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] HOLD_LONG_CYC =
    7'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SETUP_SHORT_CYC = 4'h4;
  localparam logic [3:0] SETUP_LONG_CYC = 4'h8;
  localparam logic [3:0] ADDR_BITS = 4'h8;
endpackage

// >>> rtl/tws_supervisor.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
// Contract
// - Client irq when data or addr-stop flag set
// - Host irq when read or write done set
// - Events set matching host or client flag
// - OR conditions into one line per side
// - Bus tracking and address match run asleep
// - Stretch clock low asleep until clock ready
// - Host side halted in every sleep mode
// - Dual mode wakes only on client start
// - Debug halt stops unless run bit set
// - Halted data access starts nothing, no flags
// - Threshold bit selects standard or SMBus level
// - Setup stretch four or eight cycles
// - Hold field selects none, short, 300, 500 ns
// - Fast-plus for all, or host in dual
// - Dual hold field for client, dual only
// - Dual threshold bit for client, dual only
// - Host irq gated by enables and global enable
// - Halted without run ignores incoming events
module tws_supervisor (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor and power state
  input wire logic cpu_halted,
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire logic main_clk_ready,
  // Events from the transfer engines
  input wire logic host_read_done_set,
  input wire logic host_write_done_set,
  input wire logic client_data_set,
  input wire logic client_addr_stop_set,
  input wire logic client_setup_start,
  // Two-wire pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt lines and wake
  output logic host_irq,
  output logic client_irq,
  output logic wake_request,
  // Effective engine configuration
  output logic host_run,
  output logic client_run,
  output logic host_fast_plus,
  output logic client_fast_plus,
  output logic host_input_threshold,
  output logic client_input_threshold,
  output logic [6:0] host_hold_cycles,
  output logic [6:0] client_hold_cycles,
  // Data register strobes to the engines
  output logic host_data_rd_stb,
  output logic host_data_wr_stb,
  output logic client_data_rd_stb,
  output logic client_data_wr_stb
);

  // Register storage
  logic [7:0] common_config_q;
  logic [7:0] dual_mode_config_q;
  logic [7:0] debug_halt_control_q;
  logic [7:0] host_control_first_q;
  logic [7:0] host_control_second_q;
  logic [7:0] host_status_q;
  logic [7:0] host_baud_divider_q;
  logic [7:0] host_target_address_q;
  logic [7:0] host_data_q;
  logic [7:0] client_control_first_q;
  logic [7:0] client_control_second_q;
  logic [7:0] client_status_q;
  logic [7:0] client_own_address_q;
  logic [7:0] client_data_q;
  logic [7:0] client_address_mask_q;
  // Bus decode
  logic [3:0] reg_idx;
  logic mapped;
  logic wr_access;
  logic rd_access;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;
  // Dual mode and debug qualifiers
  logic dual_on;
  logic run_halted;
  logic debug_stop;
  logic events_ok;
  // Pin synchronisers and edge history
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic bus_busy_q;
  // Address capture
  logic [7:0] addr_shift_q;
  logic [3:0] addr_cnt_q;
  logic addr_active_q;
  logic addr_match;
  logic addr_hit;
  // Clock stretch state
  logic wake_stretch_q;
  logic [3:0] setup_cnt_q;
  logic [6:0] hold_cnt_d;
  logic [6:0] hold_cli_d;
  // Word aligned decode of the fifteen byte registers
  assign reg_idx = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) &&
                  (reg_idx <= tws_pkg::IDX_CLIENT_ADDRESS_MASK);
  assign wr_access = psel && penable && pwrite && mapped;
  assign rd_access = psel && penable && !pwrite && mapped;
  assign wbyte = pwdata[7:0];
  // Zero wait state slave; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // Dual mode and debug qualifiers
  assign dual_on = dual_mode_config_q[tws_pkg::BIT_DUAL_ENABLE];
  assign run_halted = debug_halt_control_q[tws_pkg::BIT_RUN_HALTED];
  assign debug_stop = cpu_halted && !run_halted;
  assign events_ok = !debug_stop;

  // Host runs only when enabled, awake and not stopped by debug
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_run <= 1'b0;
      client_run <= 1'b0;
    end else begin
      host_run <= host_control_first_q[tws_pkg::BIT_HOST_ENABLE] &&
                  !sleep_active && !debug_stop;
      client_run <= client_control_first_q[tws_pkg::BIT_CLIENT_ENABLE] &&
                    !debug_stop;
    end
  end

  // Read multiplexer, strobe fields read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_idx)
      tws_pkg::IDX_COMMON_CONFIG: rd_mux = common_config_q;
      tws_pkg::IDX_DUAL_MODE_CONFIG: rd_mux = dual_mode_config_q;
      tws_pkg::IDX_DEBUG_HALT_CONTROL: rd_mux = debug_halt_control_q;
      tws_pkg::IDX_HOST_CONTROL_FIRST: rd_mux = host_control_first_q;
      tws_pkg::IDX_HOST_CONTROL_SECOND: rd_mux = host_control_second_q;
      tws_pkg::IDX_HOST_STATUS: begin
        rd_mux = {host_status_q[7:2],
                  bus_busy_q ? tws_pkg::BUS_BUSY : tws_pkg::BUS_IDLE};
      end
      tws_pkg::IDX_HOST_BAUD_DIVIDER: rd_mux = host_baud_divider_q;
      tws_pkg::IDX_HOST_TARGET_ADDRESS: rd_mux = host_target_address_q;
      tws_pkg::IDX_HOST_DATA: rd_mux = host_data_q;
      tws_pkg::IDX_CLIENT_CONTROL_FIRST: rd_mux = client_control_first_q;
      tws_pkg::IDX_CLIENT_CONTROL_SECOND: rd_mux = client_control_second_q;
      tws_pkg::IDX_CLIENT_STATUS: rd_mux = client_status_q;
      tws_pkg::IDX_CLIENT_OWN_ADDRESS: rd_mux = client_own_address_q;
      tws_pkg::IDX_CLIENT_DATA: rd_mux = client_data_q;
      tws_pkg::IDX_CLIENT_ADDRESS_MASK: rd_mux = client_address_mask_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data captured in the setup cycle, held through access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, mapped ? rd_mux : 8'h00};
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      common_config_q <= tws_pkg::RESET_REG;
      dual_mode_config_q <= tws_pkg::RESET_REG;
      debug_halt_control_q <= tws_pkg::RESET_REG;
      host_control_first_q <= tws_pkg::RESET_REG;
      host_control_second_q <= tws_pkg::RESET_REG;
      host_baud_divider_q <= tws_pkg::RESET_REG;
      host_target_address_q <= tws_pkg::RESET_REG;
      client_control_first_q <= tws_pkg::RESET_REG;
      client_control_second_q <= tws_pkg::RESET_REG;
      client_own_address_q <= tws_pkg::RESET_REG;
      client_address_mask_q <= tws_pkg::RESET_REG;
    end else if (wr_access) begin
      unique case (reg_idx)
        tws_pkg::IDX_COMMON_CONFIG:
          common_config_q <= wbyte & tws_pkg::MASK_COMMON;
        tws_pkg::IDX_DUAL_MODE_CONFIG:
          dual_mode_config_q <= wbyte & tws_pkg::MASK_DUAL;
        tws_pkg::IDX_DEBUG_HALT_CONTROL:
          debug_halt_control_q <= wbyte & tws_pkg::MASK_DEBUG;
        tws_pkg::IDX_HOST_CONTROL_FIRST: host_control_first_q <= wbyte;
        tws_pkg::IDX_HOST_CONTROL_SECOND:
          host_control_second_q <= wbyte & tws_pkg::MASK_HOST_CTRL2;
        tws_pkg::IDX_HOST_BAUD_DIVIDER: host_baud_divider_q <= wbyte;
        tws_pkg::IDX_HOST_TARGET_ADDRESS: host_target_address_q <= wbyte;
        tws_pkg::IDX_CLIENT_CONTROL_FIRST: client_control_first_q <= wbyte;
        tws_pkg::IDX_CLIENT_CONTROL_SECOND:
          client_control_second_q <= wbyte & tws_pkg::MASK_CLIENT_CTRL2;
        tws_pkg::IDX_CLIENT_OWN_ADDRESS: client_own_address_q <= wbyte;
        tws_pkg::IDX_CLIENT_ADDRESS_MASK: client_address_mask_q <= wbyte;
        default: begin
        end
      endcase
    end
  end

  // Data registers; a halted processor access only stores the byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_data_q <= tws_pkg::RESET_REG;
      client_data_q <= tws_pkg::RESET_REG;
    end else if (wr_access) begin
      if (reg_idx == tws_pkg::IDX_HOST_DATA) begin
        host_data_q <= wbyte;
      end
      if (reg_idx == tws_pkg::IDX_CLIENT_DATA) begin
        client_data_q <= wbyte;
      end
    end
  end

  // Engine strobes, withheld while the processor is halted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_data_rd_stb <= 1'b0;
      host_data_wr_stb <= 1'b0;
      client_data_rd_stb <= 1'b0;
      client_data_wr_stb <= 1'b0;
    end else begin
      host_data_rd_stb <= rd_access && !cpu_halted &&
                          (reg_idx == tws_pkg::IDX_HOST_DATA);
      host_data_wr_stb <= wr_access && !cpu_halted &&
                          (reg_idx == tws_pkg::IDX_HOST_DATA);
      client_data_rd_stb <= rd_access && !cpu_halted &&
                            (reg_idx == tws_pkg::IDX_CLIENT_DATA);
      client_data_wr_stb <= wr_access && !cpu_halted &&
                            (reg_idx == tws_pkg::IDX_CLIENT_DATA);
    end
  end

  // Host status: done flags set by events, cleared by writing one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_status_q <= tws_pkg::RESET_REG;
    end else begin
      if (wr_access && (reg_idx == tws_pkg::IDX_HOST_STATUS)) begin
        // Clear by one, other writable bits stored
        host_status_q[tws_pkg::BIT_READ_DONE] <=
          host_status_q[tws_pkg::BIT_READ_DONE] &
          !wbyte[tws_pkg::BIT_READ_DONE];
        host_status_q[tws_pkg::BIT_WRITE_DONE] <=
          host_status_q[tws_pkg::BIT_WRITE_DONE] &
          !wbyte[tws_pkg::BIT_WRITE_DONE];
        host_status_q[5:0] <= wbyte[5:0] & tws_pkg::MASK_HOST_STATUS_RW[5:0];
      end
      // Set wins over a clear in the same cycle
      if (host_read_done_set && events_ok) begin
        host_status_q[tws_pkg::BIT_READ_DONE] <= 1'b1;
      end
      if (host_write_done_set && events_ok) begin
        host_status_q[tws_pkg::BIT_WRITE_DONE] <= 1'b1;
      end
    end
  end

  // Client status: data and address-stop flags, same discipline
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      client_status_q <= tws_pkg::RESET_REG;
    end else begin
      if (wr_access && (reg_idx == tws_pkg::IDX_CLIENT_STATUS)) begin
        client_status_q[tws_pkg::BIT_DATA_FLAG] <=
          client_status_q[tws_pkg::BIT_DATA_FLAG] &
          !wbyte[tws_pkg::BIT_DATA_FLAG];
        client_status_q[tws_pkg::BIT_ADDR_STOP_FLAG] <=
          client_status_q[tws_pkg::BIT_ADDR_STOP_FLAG] &
          !wbyte[tws_pkg::BIT_ADDR_STOP_FLAG];
        client_status_q[5:0] <=
          wbyte[5:0] & tws_pkg::MASK_CLIENT_STATUS_RW[5:0];
      end
      if (client_data_set && events_ok) begin
        client_status_q[tws_pkg::BIT_DATA_FLAG] <= 1'b1;
      end
      if (client_addr_stop_set && events_ok) begin
        client_status_q[tws_pkg::BIT_ADDR_STOP_FLAG] <= 1'b1;
      end
    end
  end

  // Combined request lines, one per side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_irq <= 1'b0;
      client_irq <= 1'b0;
    end else begin
      host_irq <= global_irq_enable &&
        ((host_status_q[tws_pkg::BIT_READ_DONE] &&
          host_control_first_q[tws_pkg::BIT_HOST_READ_IEN]) ||
         (host_status_q[tws_pkg::BIT_WRITE_DONE] &&
          host_control_first_q[tws_pkg::BIT_HOST_WRITE_IEN]));
      client_irq <= client_status_q[tws_pkg::BIT_DATA_FLAG] ||
                    client_status_q[tws_pkg::BIT_ADDR_STOP_FLAG];
    end
  end

  // Two flip-flop synchronisers on the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Start, stop and clock rise from the synchronised levels
  assign start_det = scl_sync_q[1] && scl_prev_q &&
                     sda_prev_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_prev_q &&
                    !sda_prev_q && sda_sync_q[1];
  assign scl_rise = scl_sync_q[1] && !scl_prev_q;

  // Bus state tracking, running in every power state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_busy_q <= 1'b0;
    end else if (start_det) begin
      bus_busy_q <= 1'b1;
    end else if (stop_det) begin
      bus_busy_q <= 1'b0;
    end
  end

  // Address byte capture after each start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_shift_q <= 8'h00;
      addr_cnt_q <= 4'h0;
      addr_active_q <= 1'b0;
    end else if (start_det) begin
      addr_cnt_q <= 4'h0;
      addr_active_q <= 1'b1;
    end else if (stop_det) begin
      addr_active_q <= 1'b0;
    end else if (addr_active_q && scl_rise) begin
      addr_shift_q <= {addr_shift_q[6:0], sda_sync_q[1]};
      addr_cnt_q <= addr_cnt_q + 4'h1;
      if (addr_cnt_q == tws_pkg::ADDR_BITS - 4'h1) begin
        addr_active_q <= 1'b0;
      end
    end
  end

  // Own address match with mask, or general call when allowed
  assign addr_match =
    (((addr_shift_q[7:1] ^ client_own_address_q[7:1]) &
      ~client_address_mask_q[7:1]) == 7'h00) ||
    ((addr_shift_q[7:1] == 7'h00) && client_own_address_q[0]);
  assign addr_hit = addr_match && (addr_cnt_q == tws_pkg::ADDR_BITS) &&
                    !addr_active_q && bus_busy_q;

  // Wake stretch: hold clock low from address hit to clock ready
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_stretch_q <= 1'b0;
    end else if (main_clk_ready) begin
      wake_stretch_q <= 1'b0;
    end else if (sleep_active && addr_hit) begin
      wake_stretch_q <= 1'b1;
    end
  end

  // Wake request; dual mode wakes only on a start seen by the client
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_request <= 1'b0;
    end else if (!sleep_active) begin
      wake_request <= 1'b0;
    end else if (dual_on) begin
      wake_request <= wake_request || start_det;
    end else begin
      wake_request <= wake_request || addr_hit;
    end
  end

  // Data setup stretch counter, four or eight cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      setup_cnt_q <= 4'h0;
    end else if (client_setup_start && client_run) begin
      setup_cnt_q <= common_config_q[tws_pkg::BIT_DATA_SETUP] ?
                     tws_pkg::SETUP_LONG_CYC :
                     tws_pkg::SETUP_SHORT_CYC;
    end else if (setup_cnt_q != 4'h0) begin
      setup_cnt_q <= setup_cnt_q - 4'h1;
    end
  end

  // Open drain drive: data never pulled low, clock low while stretching
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = 1'b0;
  assign scl_oe = wake_stretch_q || (setup_cnt_q != 4'h0);

  // Hold field to cycle count, host and client variants
  function automatic logic [6:0] hold_cycles(input logic [1:0] sel);
    logic [6:0] cyc;
    cyc = 7'h00;
    unique case (sel)
      2'h0: cyc = 7'h00;
      2'h1: cyc = tws_pkg::HOLD_SHORT_CYC;
      2'h2: cyc = tws_pkg::HOLD_NOMINAL_CYC;
      2'h3: cyc = tws_pkg::HOLD_LONG_CYC;
    endcase
    return cyc;
  endfunction
  assign hold_cnt_d = hold_cycles(
    common_config_q[tws_pkg::BIT_HOLD_HI:tws_pkg::BIT_HOLD_LO]);
  assign hold_cli_d = dual_on ? hold_cycles(
    dual_mode_config_q[tws_pkg::BIT_HOLD_HI:tws_pkg::BIT_HOLD_LO]) :
    hold_cnt_d;

  // Effective speed, threshold and hold per side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_fast_plus <= 1'b0;
      client_fast_plus <= 1'b0;
      host_input_threshold <= 1'b0;
      client_input_threshold <= 1'b0;
      host_hold_cycles <= 7'h00;
      client_hold_cycles <= 7'h00;
    end else begin
      host_fast_plus <= common_config_q[tws_pkg::BIT_FAST_PLUS];
      client_fast_plus <= dual_on ?
        dual_mode_config_q[tws_pkg::BIT_FAST_PLUS] :
        common_config_q[tws_pkg::BIT_FAST_PLUS];
      host_input_threshold <=
        common_config_q[tws_pkg::BIT_INPUT_THRESHOLD];
      client_input_threshold <= dual_on ?
        dual_mode_config_q[tws_pkg::BIT_INPUT_THRESHOLD] :
        common_config_q[tws_pkg::BIT_INPUT_THRESHOLD];
      host_hold_cycles <= hold_cnt_d;
      client_hold_cycles <= hold_cli_d;
    end
  end

endmodule

// >>> tb/tb_tws_supervisor.sv
`timescale 1ns/10ps
module tb_tws_supervisor;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, n;
  logic cpu_halted = 1'b0, global_irq_enable = 1'b0;
  logic sleep_active = 1'b0, main_clk_ready = 1'b1;
  logic [4:0] evt = 5'h00; // Event pulses into the block
  logic pready, pslverr, err, scl_in, sda_in, scl_oe, sda_oe;
  logic host_irq, client_irq, wake_request, host_run, client_run;
  logic host_fast_plus, client_fast_plus, host_data_wr_stb;
  logic host_input_threshold, client_input_threshold;
  logic [6:0] host_hold_cycles, client_hold_cycles;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  tws_supervisor DUT (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_halted, .global_irq_enable,
    .sleep_active, .main_clk_ready, .host_read_done_set(evt[0]),
    .host_write_done_set(evt[1]), .client_data_set(evt[2]),
    .client_addr_stop_set(evt[3]), .client_setup_start(evt[4]),
    .scl_in, .sda_in, .scl_out(), .scl_oe, .sda_out(), .sda_oe, .host_irq,
    .client_irq, .wake_request, .host_run, .client_run, .host_fast_plus,
    .client_fast_plus, .host_input_threshold, .client_input_threshold,
    .host_hold_cycles, .client_hold_cycles, .host_data_rd_stb(),
    .host_data_wr_stb, .client_data_rd_stb(), .client_data_wr_stb());
  tws_bus_model u_bus (.scl_oe, .sda_oe, .scl_in, .sda_in);
  initial forever #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, released after pready
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] m);
    evt <= m;
    @(posedge clk);
    evt <= 5'h00;
  endtask
  task automatic nx(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic t_regs;
    apb(0, tws_pkg::IDX_COMMON_CONFIG, 8'h00);
    chk(rd, 32'h0);
    apb(0, 4'hf, 8'h00);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask
  task automatic t_irq;
    global_irq_enable <= 1'b1;
    apb(1, tws_pkg::IDX_HOST_CONTROL_FIRST, 8'hc0);
    pulse(5'h05);
    nx(3);
    chk({host_irq, client_irq}, 2'h3);
    @(posedge clk);
    apb(0, tws_pkg::IDX_HOST_STATUS, 8'h00);
    chk(rd[7:6], 2'h2);
    global_irq_enable <= 1'b0;
    apb(1, tws_pkg::IDX_HOST_STATUS, 8'h80);
    pulse(5'h02);
    nx(3);
    chk(host_irq, 1'b0);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    nx(2);
    chk(host_irq, 1'b1);
    @(posedge clk);
    apb(1, tws_pkg::IDX_HOST_STATUS, 8'h40);
    apb(1, tws_pkg::IDX_CLIENT_STATUS, 8'hc0);
  endtask
  task automatic t_cfg;
    logic [6:0] hx [4] = '{7'h00, tws_pkg::HOLD_SHORT_CYC,
      tws_pkg::HOLD_NOMINAL_CYC, tws_pkg::HOLD_LONG_CYC};
    apb(1, tws_pkg::IDX_DUAL_MODE_CONFIG, 8'h4e);
    for (int h = 0; h < 4; h++) begin
      apb(1, tws_pkg::IDX_COMMON_CONFIG, 8'(h << 2));
      nx(2);
      chk({host_hold_cycles, client_hold_cycles}, {hx[h], hx[h]});
      @(posedge clk);
    end
    apb(1, tws_pkg::IDX_COMMON_CONFIG, 8'hff);
    apb(0, tws_pkg::IDX_COMMON_CONFIG, 8'h00);
    chk(rd, {24'h0, tws_pkg::MASK_COMMON});
    apb(1, tws_pkg::IDX_DUAL_MODE_CONFIG, 8'h09);
    nx(2);
    chk({host_fast_plus, client_fast_plus, host_input_threshold,
      client_input_threshold, client_hold_cycles}, {4'ha, hx[2]});
    @(posedge clk);
    apb(1, tws_pkg::IDX_DUAL_MODE_CONFIG, 8'h00);
    apb(1, tws_pkg::IDX_CLIENT_CONTROL_FIRST, 8'h01);
    for (int s = 0; s < 2; s++) begin
      apb(1, tws_pkg::IDX_COMMON_CONFIG, 8'(s << 4));
      pulse(5'h10);
      n = 0;
      repeat (12) begin
        @(negedge clk);
        n += scl_oe;
      end
      chk(n, s ? 8 : 4);
      @(posedge clk);
    end
  endtask
  task automatic t_dbg;
    cpu_halted <= 1'b1;
    pulse(5'h08);
    apb(0, tws_pkg::IDX_CLIENT_STATUS, 8'h00);
    chk(rd[6], 1'b0);
    apb(1, tws_pkg::IDX_DEBUG_HALT_CONTROL, 8'h01);
    pulse(5'h08);
    apb(1, tws_pkg::IDX_HOST_DATA, 8'h55);
    apb(0, tws_pkg::IDX_CLIENT_STATUS, 8'h00);
    chk(rd[6], 1'b1);
    cpu_halted <= 1'b0;
    apb(1, tws_pkg::IDX_CLIENT_STATUS, 8'h40);
  endtask
  task automatic t_sleep;
    apb(1, tws_pkg::IDX_HOST_CONTROL_FIRST, 8'h01);
    apb(1, tws_pkg::IDX_CLIENT_OWN_ADDRESS, 8'h84);
    main_clk_ready <= 1'b0;
    sleep_active <= 1'b1;
    nx(3);
    chk(host_run, 1'b0);
    u_bus.send_addr(8'h84);
    nx(4);
    chk({scl_oe, wake_request}, 2'h3);
    @(posedge clk);
    main_clk_ready <= 1'b1;
    nx(3);
    chk(scl_oe, 1'b0);
    u_bus.send_stop;
    @(posedge clk);
    sleep_active <= 1'b0;
    nx(3);
    chk({wake_request, host_run}, 2'h1);
    @(posedge clk);
    apb(1, tws_pkg::IDX_DUAL_MODE_CONFIG, 8'h01);
    sleep_active <= 1'b1;
    u_bus.send_addr(8'h10);
    nx(4);
    chk({scl_oe, wake_request}, 2'h1);
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_irq;
    t_cfg;
    t_dbg;
    t_sleep;
    give_verdict;
  end
endmodule

// >>> tb/tws_bus_model.sv
`timescale 1ns/10ps
module tws_bus_model (
  // Device pull-down enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Wire levels seen by the device
  output logic scl_in,
  output logic sda_in
);
  logic scl_m = 1'b1; // Clock drive, stands high between frames
  logic sda_m = 1'b1; // Data drive, released high
  // Pull-ups make each wire a wired AND
  assign scl_in = scl_m & ~scl_oe;
  assign sda_in = sda_m & ~sda_oe;
  // Start, then one address byte MSB first
  task automatic send_addr(input logic [7:0] a);
    sda_m = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #32 scl_m = 1'b0;
      sda_m = a[i];
      #32 scl_m = 1'b1;
    end
    #32 scl_m = 1'b0;
    sda_m = 1'b1;
  endtask
  // Stop, honouring any clock stretch first
  task automatic send_stop;
    sda_m = 1'b0;
    #32 scl_m = 1'b1;
    wait (scl_in === 1'b1);
    #32 sda_m = 1'b1;
  endtask
endmodule

// >>> tb/tws_supervisor_sva.sv
`timescale 1ns/10ps
module tws_supervisor_sva (
  // Clock, reset, bus
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // State and events
  input wire logic cpu_halted,
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire logic client_data_set,
  input wire logic client_setup_start,
  // Outputs watched
  input wire logic client_run,
  input wire logic scl_oe,
  input wire logic host_irq,
  input wire logic client_irq,
  input wire logic wake_request,
  input wire logic host_run,
  input wire logic [6:0] host_hold_cycles,
  input wire logic host_data_wr_stb
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Accepted event and accepted stretch request
  sequence s_evt; client_data_set && !cpu_halted; endsequence
  sequence s_str; client_setup_start && client_run; endsequence
  property p_cirq; s_evt |-> ##2 client_irq; endproperty
  property p_hgate; host_irq |-> $past(global_irq_enable); endproperty
  property p_chold;
    client_irq && !$past(psel && penable && pwrite) |=> client_irq;
  endproperty
  property p_wake; !sleep_active [*2] |-> !wake_request; endproperty
  property p_hslp; sleep_active [*2] |-> !host_run; endproperty
  property p_dbg; cpu_halted [*2] |-> !host_data_wr_stb; endproperty
  property p_setup; s_str |=> scl_oe [*4]; endproperty
  property p_hold;
    host_hold_cycles inside {7'h00, 7'h0a, 7'h3c, 7'h64};
  endproperty
  a_cirq: assert property (p_cirq) else $error("client irq late");
  a_hgate: assert property (p_hgate) else $error("host irq ungated");
  a_chold: assert property (p_chold) else $error("irq dropped");
  a_wake: assert property (p_wake) else $error("wake stuck");
  a_hslp: assert property (p_hslp) else $error("host runs asleep");
  a_dbg: assert property (p_dbg) else $error("strobe halted");
  a_setup: assert property (p_setup) else $error("stretch short");
  a_hold: assert property (p_hold) else $error("bad hold count");
endmodule

bind tws_supervisor tws_supervisor_sva u_sva (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite),
  .cpu_halted(cpu_halted), .global_irq_enable(global_irq_enable),
  .sleep_active(sleep_active), .client_data_set(client_data_set),
  .client_setup_start(client_setup_start), .client_run(client_run),
  .scl_oe(scl_oe), .host_irq(host_irq), .client_irq(client_irq),
  .wake_request(wake_request), .host_run(host_run),
  .host_hold_cycles(host_hold_cycles),
  .host_data_wr_stb(host_data_wr_stb));
